// *** rtl/ibk_bank.sv ***
// Interrupt flag and enable register bank with request priority encoder.
`timescale 1ns/1ps
`default_nettype none
module ibk_bank
  import ibk_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire ibk_cpu_req_t cpu_req_i,
  output logic [7:0]        cpu_rdata_o,
  input  wire ibk_evt_t     evt_i,
  input  wire logic         ext_pin_zero_i,
  input  wire logic         ext_pin_one_i,
  output logic              irq_req_o,
  output ibk_src_t          irq_src_o,
  input  wire logic         irq_ack_i
);

  // ========================================================================
  // Helpers
  function automatic logic edge_hit(input logic [1:0] trig,
                                    input logic       prev,
                                    input logic       now);
    edge_hit = ((trig == TRIG_RISE) && !prev && now)  ||
               ((trig == TRIG_FALL) && prev && !now)  ||
               ((trig == TRIG_BOTH) && (prev != now));
  endfunction : edge_hit

  function automatic logic [7:0] wr_val(input logic [7:0] cur,
                                        input logic [2:0] sel,
                                        input logic [7:0] mask);
    wr_val = (cpu_req_i.wr && cpu_req_i.sel == sel) ?
             (cpu_req_i.wdata & mask) : cur;
  endfunction : wr_val

  // ========================================================================
  // State
  logic [7:0] edge_ff, ctrl0_ff, ctrl1_ff, grp0_ff, grp1_ff;
  logic [7:0] nxt_edge, nxt_ctrl0, nxt_ctrl1, nxt_grp0, nxt_grp1;
  logic       pin0_prev_ff, pin1_prev_ff;
  logic       req_ff;
  ibk_src_t   src_ff;
  logic [7:0] rdata_ff;
  logic       ack_ok;
  logic       pin0_hit, pin1_hit, grp0_set, grp1_set;
  logic [6:0] pend;
  logic       nxt_req;
  ibk_src_t   nxt_src;

  assign ack_ok   = irq_ack_i && req_ff;
  assign pin0_hit = edge_hit(edge_ff[EDGE_PIN0_LSB +: 2], pin0_prev_ff,
                             ext_pin_zero_i);
  assign pin1_hit = edge_hit(edge_ff[EDGE_PIN1_LSB +: 2], pin1_prev_ff,
                             ext_pin_one_i);

  // ========================================================================
  // Pin history. Reset low; edge selects reset to off, so a pin already high at reset raises no flag.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin0_prev_ff <= 1'b0;
      pin1_prev_ff <= 1'b0;
    end else begin
      pin0_prev_ff <= ext_pin_zero_i;
      pin1_prev_ff <= ext_pin_one_i;
    end
  end

  // ========================================================================
  // Next register values. Hardware sets win over software or service clears.
  always_comb begin
    nxt_edge = wr_val(edge_ff, SEL_EDGE, MASK_EDGE);
    nxt_grp0 = wr_val(grp0_ff, SEL_GROUP0, MASK_GROUP0);
    nxt_grp0[GRP_FLAG_LSB]     = nxt_grp0[GRP_FLAG_LSB] | evt_i.t0_period;
    nxt_grp0[GRP_FLAG_LSB + 1] = nxt_grp0[GRP_FLAG_LSB + 1] |
                                 evt_i.t0_a_match;
    nxt_grp1 = wr_val(grp1_ff, SEL_GROUP1, MASK_GROUP1);
    nxt_grp1[GRP_FLAG_LSB]     = nxt_grp1[GRP_FLAG_LSB] | evt_i.t1_period;
    nxt_grp1[GRP_FLAG_LSB + 1] = nxt_grp1[GRP_FLAG_LSB + 1] |
                                 evt_i.t1_a_match;
    nxt_grp1[GRP_FLAG_LSB + 2] = nxt_grp1[GRP_FLAG_LSB + 2] |
                                 evt_i.t1_b_match;
    // A member flag that newly rises raises its group flag.
    grp0_set = |(nxt_grp0 & ~grp0_ff & (MASK_GROUP0 & 8'hF0));
    grp1_set = |(nxt_grp1 & ~grp1_ff & (MASK_GROUP1 & 8'hF0));

    nxt_ctrl0 = wr_val(ctrl0_ff, SEL_CTRL0, MASK_CTRL0);
    nxt_ctrl1 = wr_val(ctrl1_ff, SEL_CTRL1, MASK_CTRL1);
    if (ack_ok) begin
      nxt_ctrl0[C0_GLOBAL_EN] = 1'b0;
      case (src_ff)
        SRC_PIN0:  nxt_ctrl0[C0_PIN0_FLAG]  = 1'b0;
        SRC_PIN1:  nxt_ctrl0[C0_PIN1_FLAG]  = 1'b0;
        SRC_GRP0:  nxt_ctrl0[C0_GRP0_FLAG]  = 1'b0;
        SRC_GRP1:  nxt_ctrl1[C1_GRP1_FLAG]  = 1'b0;
        SRC_CONV:  nxt_ctrl1[C1_CONV_FLAG]  = 1'b0;
        SRC_TBASE: nxt_ctrl1[C1_TBASE_FLAG] = 1'b0;
        SRC_VDET:  nxt_ctrl1[C1_VDET_FLAG]  = 1'b0;
        default:   nxt_ctrl1 = nxt_ctrl1;
      endcase
    end
    nxt_ctrl0[C0_PIN0_FLAG]  = nxt_ctrl0[C0_PIN0_FLAG] | pin0_hit;
    nxt_ctrl0[C0_PIN1_FLAG]  = nxt_ctrl0[C0_PIN1_FLAG] | pin1_hit;
    nxt_ctrl0[C0_GRP0_FLAG]  = nxt_ctrl0[C0_GRP0_FLAG] | grp0_set;
    nxt_ctrl1[C1_GRP1_FLAG]  = nxt_ctrl1[C1_GRP1_FLAG] | grp1_set;
    nxt_ctrl1[C1_CONV_FLAG]  = nxt_ctrl1[C1_CONV_FLAG] | evt_i.converter;
    nxt_ctrl1[C1_TBASE_FLAG] = nxt_ctrl1[C1_TBASE_FLAG] | evt_i.time_base;
    nxt_ctrl1[C1_VDET_FLAG]  = nxt_ctrl1[C1_VDET_FLAG] |
                               evt_i.voltage_detect;
  end

  // ========================================================================
  // Registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_ff  <= RST_REG;
      ctrl0_ff <= RST_REG;
      ctrl1_ff <= RST_REG;
      grp0_ff  <= RST_REG;
      grp1_ff  <= RST_REG;
    end else begin
      edge_ff  <= nxt_edge;
      ctrl0_ff <= nxt_ctrl0;
      ctrl1_ff <= nxt_ctrl1;
      grp0_ff  <= nxt_grp0;
      grp1_ff  <= nxt_grp1;
    end
  end

  // ========================================================================
  // Request selection, computed from next values so source and request
  // appear together and a cleared global enable drops the request at once.
  always_comb begin
    pend[0] = nxt_ctrl0[C0_PIN0_FLAG]  & nxt_ctrl0[C0_PIN0_EN];
    pend[1] = nxt_ctrl0[C0_PIN1_FLAG]  & nxt_ctrl0[C0_PIN1_EN];
    pend[2] = nxt_ctrl0[C0_GRP0_FLAG]  & nxt_ctrl0[C0_GRP0_EN];
    pend[3] = nxt_ctrl1[C1_GRP1_FLAG]  & nxt_ctrl1[C1_GRP1_EN];
    pend[4] = nxt_ctrl1[C1_CONV_FLAG]  & nxt_ctrl1[C1_CONV_EN];
    pend[5] = nxt_ctrl1[C1_TBASE_FLAG] & nxt_ctrl1[C1_TBASE_EN];
    pend[6] = nxt_ctrl1[C1_VDET_FLAG]  & nxt_ctrl1[C1_VDET_EN];
    nxt_req = nxt_ctrl0[C0_GLOBAL_EN] && (|pend);
    nxt_src = SRC_PIN0;
    for (int i = 6; i >= 0; i--) begin
      if (pend[i]) begin
        nxt_src = ibk_src_t'(3'(i));
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_ff <= 1'b0;
      src_ff <= SRC_PIN0;
    end else begin
      req_ff <= nxt_req;
      src_ff <= nxt_src;
    end
  end

  // ========================================================================
  // Read port; unused selects and unimplemented bits read as zero.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= RST_REG;
    end else begin
      case (cpu_req_i.sel)
        SEL_EDGE:   rdata_ff <= edge_ff;
        SEL_CTRL0:  rdata_ff <= ctrl0_ff;
        SEL_CTRL1:  rdata_ff <= ctrl1_ff;
        SEL_GROUP0: rdata_ff <= grp0_ff;
        SEL_GROUP1: rdata_ff <= grp1_ff;
        default:    rdata_ff <= RST_REG;
      endcase
    end
  end

  assign cpu_rdata_o = rdata_ff;
  assign irq_req_o   = req_ff;
  assign irq_src_o   = src_ff;

  // ========================================================================
  // Checks
  // Unused bits are masked on every write path, so these hold by design;
  // they guard against a later edit that sets a bit outside its mask.
  edge_upper_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (edge_ff & ~MASK_EDGE) == 8'h00)
    else $error("edge upper bits set");
  ctrl0_top_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ctrl0_ff & ~MASK_CTRL0) == 8'h00)
    else $error("control zero bit7 set");
  grp_unused_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ((grp0_ff & ~MASK_GROUP0) | (grp1_ff & ~MASK_GROUP1)) == 8'h00)
    else $error("group unused bit set");
  pin0_rise_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (edge_ff[EDGE_PIN0_LSB +: 2] == TRIG_RISE && !pin0_prev_ff &&
     ext_pin_zero_i) |=> ctrl0_ff[C0_PIN0_FLAG])
    else $error("pin zero rise lost");
  pin0_off_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (edge_ff[EDGE_PIN0_LSB +: 2] == TRIG_OFF && !cpu_req_i.wr &&
     !ctrl0_ff[C0_PIN0_FLAG]) |=> !ctrl0_ff[C0_PIN0_FLAG])
    else $error("pin zero set while off");
  pin1_off_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (edge_ff[EDGE_PIN1_LSB +: 2] == TRIG_OFF && !cpu_req_i.wr &&
     !ctrl0_ff[C0_PIN1_FLAG]) |=> !ctrl0_ff[C0_PIN1_FLAG])
    else $error("pin one set while off");
  conv_set_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    evt_i.converter |=> ctrl1_ff[C1_CONV_FLAG])
    else $error("converter flag lost");
  conv_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (irq_ack_i && irq_req_o && irq_src_o == SRC_CONV &&
     !evt_i.converter && !cpu_req_i.wr) |=> !ctrl1_ff[C1_CONV_FLAG])
    else $error("converter flag kept after service");
  ack_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (irq_ack_i && irq_req_o) |=> !ctrl0_ff[C0_GLOBAL_EN] && !irq_req_o)
    else $error("service kept global enable");
  req_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    irq_req_o |-> ctrl0_ff[C0_GLOBAL_EN])
    else $error("request ungated");
  grp0_raise_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (evt_i.t0_period && !grp0_ff[GRP_FLAG_LSB]) |=> ctrl0_ff[C0_GRP0_FLAG])
    else $error("group zero not raised");
  // Software owns the member flags, so service must leave them alone.
  grp_keep_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (irq_ack_i && irq_req_o && irq_src_o == SRC_GRP0 && !cpu_req_i.wr)
    |=> (grp0_ff & $past(grp0_ff)) == $past(grp0_ff))
    else $error("group member flag lost on service");
  prio_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (irq_req_o && ctrl0_ff[C0_PIN0_FLAG] && ctrl0_ff[C0_PIN0_EN])
    |-> irq_src_o == SRC_PIN0)
    else $error("pin zero not first");
  pin1_first_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (irq_req_o && !(ctrl0_ff[C0_PIN0_FLAG] && ctrl0_ff[C0_PIN0_EN]) &&
     ctrl0_ff[C0_PIN1_FLAG] && ctrl0_ff[C0_PIN1_EN])
    |-> irq_src_o == SRC_PIN1)
    else $error("pin one not second");

endmodule : ibk_bank
`default_nettype wire

// *** rtl/ibk_pkg.sv ***
// Package with register layout, source codes and carriers of the bank.
`default_nettype none
// ==========================================================================
// Summary of operation
// - Pin one trigger codes: off, rise, fall, both.
// - Pin zero trigger in edge-select bits 1:0.
// - Edge-select upper four bits ignore writes, read zero.
// - Control zero: enables, pin and group flags.
// - Control one: group one, converter, time base, voltage.
// - Group zero: timer0 period and A match bits.
// - Group one: timer1 period, A and B bits.
// - Flag one means pending, enable one permits.
// - Accept pin, timer, time base, voltage, converter events.
// - Flags set regardless; request needs both enables.
// - Service clears global enable and serviced flag.
// - Group flag set when a member flag rises; members cleared by software.
// - Pin flag set on selected transition type.
package ibk_pkg;

  // ========================================================================
  // Register selects on the core data-memory port
  localparam logic [2:0] SEL_EDGE   = 3'h0;
  localparam logic [2:0] SEL_CTRL0  = 3'h1;
  localparam logic [2:0] SEL_CTRL1  = 3'h2;
  localparam logic [2:0] SEL_GROUP0 = 3'h3;
  localparam logic [2:0] SEL_GROUP1 = 3'h4;

  // ========================================================================
  // Implemented bits and reset values
  localparam logic [7:0] MASK_EDGE   = 8'h0F;
  localparam logic [7:0] MASK_CTRL0  = 8'h7F;
  localparam logic [7:0] MASK_CTRL1  = 8'hFF;
  localparam logic [7:0] MASK_GROUP0 = 8'h33;
  localparam logic [7:0] MASK_GROUP1 = 8'h77;
  localparam logic [7:0] RST_REG     = 8'h00;

  // ========================================================================
  // Field positions
  localparam int EDGE_PIN0_LSB = 0;
  localparam int EDGE_PIN1_LSB = 2;
  localparam int C0_GLOBAL_EN  = 0;
  localparam int C0_PIN0_EN    = 1;
  localparam int C0_PIN1_EN    = 2;
  localparam int C0_GRP0_EN    = 3;
  localparam int C0_PIN0_FLAG  = 4;
  localparam int C0_PIN1_FLAG  = 5;
  localparam int C0_GRP0_FLAG  = 6;
  localparam int C1_GRP1_EN    = 0;
  localparam int C1_CONV_EN    = 1;
  localparam int C1_TBASE_EN   = 2;
  localparam int C1_VDET_EN    = 3;
  localparam int C1_GRP1_FLAG  = 4;
  localparam int C1_CONV_FLAG  = 5;
  localparam int C1_TBASE_FLAG = 6;
  localparam int C1_VDET_FLAG  = 7;
  localparam int GRP_FLAG_LSB  = 4;

  // ========================================================================
  // Trigger encodings
  localparam logic [1:0] TRIG_OFF  = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;

  // ========================================================================
  // Source codes, listed in falling priority
  typedef enum logic [2:0] {
    SRC_PIN0  = 3'h0,
    SRC_PIN1  = 3'h1,
    SRC_GRP0  = 3'h2,
    SRC_GRP1  = 3'h3,
    SRC_CONV  = 3'h4,
    SRC_TBASE = 3'h5,
    SRC_VDET  = 3'h6
  } ibk_src_t;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic t0_period;
    logic t0_a_match;
    logic t1_period;
    logic t1_a_match;
    logic t1_b_match;
    logic converter;
    logic time_base;
    logic voltage_detect;
  } ibk_evt_t;

  typedef struct packed {
    logic       wr;
    logic [2:0] sel;
    logic [7:0] wdata;
  } ibk_cpu_req_t;

endpackage : ibk_pkg
`default_nettype wire

// *** testbench/ibk_bank_tb_top.sv ***
// Self-checking testbench of the interrupt flag and enable bank.
`timescale 1ns/1ps
`default_nettype none
`define IBK_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ibk_bank_tb_top
  import ibk_pkg::*;
;
  logic         core_clk = 1'b0;
  logic         rst_n    = 1'b0;
  ibk_cpu_req_t req      = '0;
  ibk_evt_t     evt      = '0;
  logic [1:0]   pin      = 2'h0;
  logic         go       = 1'b0;
  logic [1:0]   dly      = 2'h0;
  logic         ack;
  logic [7:0]   rdata;
  logic         irq_req;
  ibk_src_t     src;
  int           failures = 0;
  int           tests_run = 0;
  int           seed     = 15341;
  logic [7:0]   v, d, c0, c1;
  logic [31:0]  all;
  logic [7:0]   msk [6]  = '{MASK_EDGE, MASK_CTRL0, MASK_CTRL1,
                             MASK_GROUP0, MASK_GROUP1, 8'h00};

  ibk_bank dut (
    .core_clk_i     (core_clk),
    .rst_n_i        (rst_n),
    .cpu_req_i      (req),
    .cpu_rdata_o    (rdata),
    .evt_i          (evt),
    .ext_pin_zero_i (pin[0]),
    .ext_pin_one_i  (pin[1]),
    .irq_req_o      (irq_req),
    .irq_src_o      (src),
    .irq_ack_i      (ack)
  );
  ibk_core_model core (
    .core_clk_i (core_clk),
    .rst_n_i    (rst_n),
    .go_i       (go),
    .dly_i      (dly),
    .irq_req_i  (irq_req),
    .irq_ack_o  (ack)
  );

  // ========================================================================
  // Register port and verdict
  task automatic wr(input logic [2:0] s, input logic [7:0] x);
    @(posedge core_clk) req <= '{1'b1, s, x};
    @(posedge core_clk) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] s, output logic [7:0] x);
    @(posedge core_clk) req.sel <= s;
    @(posedge core_clk);
    @(negedge core_clk) x = rdata;
  endtask : rd
  task automatic rdall(output logic [31:0] x);
    rd(3'h1, x[31:24]);
    rd(3'h2, x[23:16]);
    rd(3'h3, x[15:8]);
    rd(3'h4, x[7:0]);
  endtask : rdall
  task automatic clr();
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
  endtask : clr
  task automatic complete_run();
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // Expected {control0, control1, group0, group1} after one event pulse.
  function automatic logic [31:0] evt_exp(input int k);
    case (k)
      0: return 32'h40001000;
      1: return 32'h40002000;
      2: return 32'h00100010;
      3: return 32'h00100020;
      4: return 32'h00100040;
      5: return 32'h00200000;
      6: return 32'h00400000;
      default: return 32'h00800000;
    endcase
  endfunction : evt_exp

  // ========================================================================
  // Clock, watchdog and scenarios
  initial forever #2 core_clk = ~core_clk;
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int s = 0; s < 6; s++) begin
      rd(3'(s), v);
      `IBK_CHK("reset", 8'h00, v)
    end
    // Pins stay still here, so random edge selects cannot raise flags.
    repeat (4) for (int s = 0; s < 6; s++) begin
      d = 8'($random(seed));
      wr(3'(s), d);
      rd(3'(s), v);
      `IBK_CHK("rw", d & msk[s], v)
    end
    clr();
    for (int i = 0; i < 2; i++) for (int t = 0; t < 4; t++) begin
      wr(3'h0, 8'(t) << (2 * i));
      @(posedge core_clk) pin[i] <= 1'b1;
      rd(3'h1, v);
      `IBK_CHK("rise", 8'(t % 2) << (4 + i), v)
      wr(3'h1, 8'h00);
      @(posedge core_clk) pin[i] <= 1'b0;
      rd(3'h1, v);
      `IBK_CHK("fall", 8'(t / 2) << (4 + i), v)
      wr(3'h1, 8'h00);
    end
    for (int k = 0; k < 8; k++) begin
      clr();
      @(posedge core_clk) evt <= ibk_evt_t'(8'h80 >> k);
      @(posedge core_clk) evt <= '0;
      rdall(all);
      `IBK_CHK("event", evt_exp(k), all)
      `IBK_CHK("no_req", 1'b0, irq_req)
    end
    go <= 1'b1;
    c0 = 8'h7F;
    c1 = 8'hFF;
    wr(3'h3, 8'h33);
    wr(3'h4, 8'h77);
    wr(3'h2, c1);
    wr(3'h1, c0);
    for (int k = 0; k < 7; k++) begin
      @(negedge core_clk);
      `IBK_CHK("req", 1'b1, irq_req)
      `IBK_CHK("src", 3'(k), src)
      for (int n = 0; n < 8 && ack !== 1'b1; n++) @(negedge core_clk);
      @(negedge core_clk);
      `IBK_CHK("served", 1'b0, irq_req)
      if (k < 3) c0[4 + k] = 1'b0;
      else c1[k + 1] = 1'b0;
      c0[0] = 1'b0;
      rd(3'h1, v);
      `IBK_CHK("ctrl0", c0, v)
      rd(3'h2, v);
      `IBK_CHK("ctrl1", c1, v)
      c0[0] = 1'b1;
      dly <= 2'($random(seed));
      wr(3'h1, c0);
    end
    rd(3'h3, v);
    `IBK_CHK("group0", 8'h33, v)
    rd(3'h4, v);
    `IBK_CHK("group1", 8'h77, v)
    complete_run();
  end
endmodule : ibk_bank_tb_top
`default_nettype wire

// *** testbench/ibk_core_model.sv ***
// Core sequencer model that services pending requests after a delay.
`timescale 1ns/1ps
`default_nettype none
module ibk_core_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       go_i,
  input  wire logic [1:0] dly_i,
  input  wire logic       irq_req_i,
  output logic            irq_ack_o
);
  logic [1:0] wait_ff;
  // ========================================================================
  // Service handshake
  // No ack on the edge after an ack: the request seen there is the old one that the bank is dropping.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ack_o <= 1'b0;
      wait_ff   <= 2'h0;
    end else begin
      irq_ack_o <= 1'b0;
      if (go_i && irq_req_i && !irq_ack_o) begin
        if (wait_ff >= dly_i) begin
          irq_ack_o <= 1'b1;
          wait_ff   <= 2'h0;
        end else begin
          wait_ff <= wait_ff + 2'h1;
        end
      end
    end
  end
endmodule : ibk_core_model
`default_nettype wire
